/* hw/tsa_pkg.sv */
// Constants shared by the two-step converter output pipeline.
// Assumes one system clock; the conversion clock arrives as a pin.
package tsa_pkg;
  // ==========================================================
  // Widths and depth
  localparam int unsigned WORD_W     = 8;
  localparam int unsigned PART_W     = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SYNC_W     = 2;
  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [PART_W-1:0] PART_RST = 4'h0;
  // ==========================================================
  // Lower comparator stage phases
  typedef enum logic [1:0] {
    tsa_idle,
    tsa_hold,
    tsa_compare
  } tsa_phase_e;
endpackage : tsa_pkg

/* hw/tsa_stage_if.sv */
// Bundle between the pipeline controller and one lower comparator stage.
// Assumes both ends run on ref_clk.
interface tsa_stage_if;
  logic                         load;
  logic                         rise;
  logic [tsa_pkg::WORD_W-1:0]   sample;
  logic [tsa_pkg::PART_W-1:0]   upper_in;
  logic [tsa_pkg::PART_W-1:0]   upper_out;
  logic [tsa_pkg::PART_W-1:0]   lower_partial_result;
  logic                         done;

  modport ctrl  (output load, output rise, output sample, output upper_in,
                 input upper_out, input lower_partial_result, input done);
  modport stage (input load, input rise, input sample, input upper_in,
                 output upper_out, output lower_partial_result, output done);
endinterface : tsa_stage_if

/* hw/tsa_lower_stage.sv */
// One lower comparator stage: sample, hold on the upper result, compare.
// Assumes load and rise never fall in the same ref_clk cycle, and that upper_in
// carries the upper result of this stage's own sample at its compare rise.
module tsa_lower_stage (
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  tsa_stage_if.stage   port_s
);
  tsa_pkg::tsa_phase_e             phase;
  logic [tsa_pkg::WORD_W-1:0]      held;
  logic [tsa_pkg::PART_W-1:0]      ref_sel;
  logic [tsa_pkg::PART_W-1:0]      lower;
  logic                            done_q;
  logic [tsa_pkg::WORD_W-1:0]      residue;

  // Residue against the reference picked by the upper result
  assign residue = held - {port_s.upper_in, tsa_pkg::PART_RST};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase   <= tsa_pkg::tsa_idle;
      held    <= tsa_pkg::WORD_RST;
      ref_sel <= tsa_pkg::PART_RST;
      lower   <= tsa_pkg::PART_RST;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (port_s.load)
      begin
        held  <= port_s.sample;
        phase <= tsa_pkg::tsa_hold;
      end
      else if (port_s.rise)
      begin
        case (phase)
          tsa_pkg::tsa_hold:
          begin
            phase   <= tsa_pkg::tsa_compare;
          end
          tsa_pkg::tsa_compare:
          begin
            // Keep the reference with the result; the upper register moves on at this edge
            ref_sel <= port_s.upper_in;
            lower  <= residue[tsa_pkg::PART_W-1:0];
            done_q <= 1'b1;
            phase  <= tsa_pkg::tsa_idle;
          end
          default: phase <= tsa_pkg::tsa_idle;
        endcase
      end
    end
  end

  assign port_s.upper_out            = ref_sel;
  assign port_s.lower_partial_result = lower;
  assign port_s.done                 = done_q;
endmodule : tsa_lower_stage

/* hw/tsa_fifo.sv */
// Word FIFO with registered read data and show-ahead output.
// Assumes push and pop come from logic on the same clock.
module tsa_fifo #(
  parameter int unsigned WIDTH = tsa_pkg::WORD_W,
  parameter int unsigned DEPTH = tsa_pkg::FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             head_bypass;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready    = (count != (AW + 1)'(DEPTH));
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
  assign next_count  = count + (AW + 1)'(push) - (AW + 1)'(pop);
  // A word written straight into the head slot would be read stale from memory
  assign head_bypass = push && (wr_ptr == next_rd_ptr);

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= bump(wr_ptr);
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= (next_count != '0);
      out_data  <= head_bypass ? in_data : mem[next_rd_ptr];
    end
  end
endmodule : tsa_fifo

/* hw/tsa_pipeline.sv */
// Digital timing of an 8-bit two-step converter: upper stage, two lower
// stages used in turn, merge, and the output bus.
// Assumes conv_clk and analog_sample come from pins and ref_clk is at least
// four times faster than conv_clk so every half period spans two ref_clk edges.

// What this block does
// - Sample, hold and compare phases all step on edges of the one external conversion clock.
// - A sample is taken on a falling clock edge into the upper stage and its lower stage together.
// - The 4-bit upper result is ready at the first rising edge after sampling.
// - The 4-bit lower result is ready at the second rising edge, against the reference picked by the upper result.
// - Upper and lower results merge into one byte driven out at the third rising edge.
// - Each byte appears two and a half clock cycles after its sampling falling edge.
// - Consecutive samples go to the two lower stages in turn so a conversion starts every cycle.
// - After the first latency one byte comes out on every rising edge.
// - The byte is straight binary with bit 7 as most significant, bottom reference 0 and top 255.
// - Every code from 0 to 255 is reachable across the input range.
module tsa_pipeline (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  input  wire logic                        conv_clk,
  input  wire logic [tsa_pkg::WORD_W-1:0]  analog_sample,
  output logic      [tsa_pkg::WORD_W-1:0]  out_word,
  output logic                             word_strobe,
  output logic                             overflow
);
  // ==========================================================
  // Pin synchronisers
  logic [tsa_pkg::SYNC_W-1:0]      clk_sync;
  logic                            clk_last;
  logic [tsa_pkg::WORD_W-1:0]      samp_meta;
  logic [tsa_pkg::WORD_W-1:0]      samp_sync;
  logic                            fall_edge;
  logic                            rise_edge;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_sync  <= '0;
      clk_last  <= 1'b0;
      samp_meta <= tsa_pkg::WORD_RST;
      samp_sync <= tsa_pkg::WORD_RST;
    end
    else
    begin
      clk_sync  <= {clk_sync[0], conv_clk};
      clk_last  <= clk_sync[1];
      samp_meta <= analog_sample;
      samp_sync <= samp_meta;
    end
  end

  // Only the second and third flops feed the edge detector
  assign fall_edge = clk_last && !clk_sync[1];
  assign rise_edge = !clk_last && clk_sync[1];

  // ==========================================================
  // Sampling and upper stage
  logic                            stage_sel;
  logic [tsa_pkg::WORD_W-1:0]      upper_held;
  logic [tsa_pkg::PART_W-1:0]      upper_partial_result;
  logic                            load_a;
  logic                            load_b;

  assign load_a = fall_edge && !stage_sel;
  assign load_b = fall_edge && stage_sel;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_sel            <= 1'b0;
      upper_held           <= tsa_pkg::WORD_RST;
      upper_partial_result <= tsa_pkg::PART_RST;
    end
    else
    begin
      if (fall_edge)
      begin
        upper_held <= samp_sync;
        stage_sel  <= !stage_sel;
      end
      if (rise_edge)
        upper_partial_result <= upper_held[tsa_pkg::WORD_W-1:tsa_pkg::PART_W];
    end
  end

  // ==========================================================
  // Lower stages, used alternately
  tsa_stage_if lane_a ();
  tsa_stage_if lane_b ();

  // At the compare rise the upper register still holds the result of the rise before
  assign lane_a.load     = load_a;
  assign lane_a.rise     = rise_edge;
  assign lane_a.sample   = samp_sync;
  assign lane_a.upper_in = upper_partial_result;
  assign lane_b.load     = load_b;
  assign lane_b.rise     = rise_edge;
  assign lane_b.sample   = samp_sync;
  assign lane_b.upper_in = upper_partial_result;

  tsa_lower_stage u_stage_a (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .port_s  (lane_a.stage)
  );

  tsa_lower_stage u_stage_b (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .port_s  (lane_b.stage)
  );

  // ==========================================================
  // Merge into a straight binary byte and queue it
  logic                            push_valid;
  logic [tsa_pkg::WORD_W-1:0]      merged;
  logic                            push_ready;
  logic                            head_valid;
  logic [tsa_pkg::WORD_W-1:0]      head_word;
  logic                            pop_now;

  assign push_valid = lane_a.done || lane_b.done;
  // Upper nibble on top keeps the code straight binary and gap free
  assign merged     = lane_a.done ? {lane_a.upper_out, lane_a.lower_partial_result}
                                  : {lane_b.upper_out, lane_b.lower_partial_result};
  assign pop_now    = rise_edge && head_valid;

  tsa_fifo #(
    .WIDTH (tsa_pkg::WORD_W),
    .DEPTH (tsa_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (merged),
    .out_valid (head_valid),
    .out_ready (pop_now),
    .out_data  (head_word)
  );

  // ==========================================================
  // Output bus
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_word    <= tsa_pkg::WORD_RST;
      word_strobe <= 1'b0;
      overflow    <= 1'b0;
    end
    else
    begin
      word_strobe <= pop_now;
      if (pop_now)
        out_word <= head_word;
      // A full queue means the conversion clock outran ref_clk; the word is lost
      if (push_valid && !push_ready)
        overflow <= 1'b1;
    end
  end
endmodule : tsa_pipeline

/* tb/tsa_pipeline_chk.sv */
// Port checker for the converter output pipeline, bound to its top.
// Assumes conv_clk halves of 4 to 7 ref_clk cycles while it runs.
module tsa_pipeline_chk (
  input wire logic                       ref_clk,
  input wire logic                       rst_b,
  input wire logic                       conv_clk,
  input wire logic [tsa_pkg::WORD_W-1:0] analog_sample,
  input wire logic [tsa_pkg::WORD_W-1:0] out_word,
  input wire logic                       word_strobe,
  input wire logic                       overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Cycles since the last word, saturating
  logic [4:0] idle;
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      idle <= 5'h1f;
    else if (word_strobe)
      idle <= 5'h00;
    else if (idle != 5'h1f)
      idle <= idle + 5'h01;
  // ==========================================
  // Properties
  a_strobe_one_cycle: assert property (word_strobe |=> !word_strobe)
    else $error("strobe wider than one cycle");
  a_word_holds: assert property (!word_strobe |-> $stable(out_word))
    else $error("output word changed without strobe");
  a_strobe_after_rise: assert property (word_strobe |->
    ($past(conv_clk, 3) && !$past(conv_clk, 4)) || ($past(conv_clk, 4) && !$past(conv_clk, 5)))
    else $error("strobe not tied to a clock rise");
  a_word_per_rise: assert property ($rose(conv_clk) && idle < 5'h10 |-> ##[3:4] word_strobe)
    else $error("missing word after a rise");
  a_quiet_idle: assert property ($stable(conv_clk) [*6] |-> !word_strobe)
    else $error("word without conversion clock");
  a_overflow_sticky: assert property (overflow |=> overflow)
    else $error("overflow flag cleared");
  a_no_word_lost: assert property (!overflow)
    else $error("word lost at full buffer");
  a_rst_clear: assert property (disable iff (1'b0) !rst_b |-> out_word == 8'h00 && !word_strobe)
    else $error("outputs not cleared in reset");
  c_word: cover property (word_strobe);
  c_top: cover property (word_strobe && out_word == 8'hff);
  c_bottom: cover property (word_strobe && out_word == 8'h00);
endmodule : tsa_pipeline_chk

bind tsa_pipeline tsa_pipeline_chk chk (.ref_clk(ref_clk), .rst_b(rst_b), .conv_clk(conv_clk),
  .analog_sample(analog_sample), .out_word(out_word), .word_strobe(word_strobe), .overflow(overflow));

/* tb/tsa_host.sv */
// Host model: makes the conversion clock and drives the input level.
// Assumes run, half and level come from the bench; half is 4 or more.
module tsa_host (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [2:0] half,
  input  wire logic [7:0] level,
  output logic            conv_clk,
  output logic [7:0]      analog_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial conv_clk = 1'b0;
  initial analog_sample = 8'h00;
  // Clock only stops low; level is junk for one cycle after each rise
  always @(posedge ref_clk)
  begin
    #1;
    cnt = cnt + 1;
    if (cnt == 1 && conv_clk)
      analog_sample = level;
    if (cnt >= half && (run || conv_clk))
    begin
      conv_clk = !conv_clk;
      cnt = 0;
      if (conv_clk)
        analog_sample = ~analog_sample;
    end
  end
endmodule : tsa_host

/* tb/tsa_pipeline_tb.sv */
// Self-checking bench for the converter output pipeline.
// Assumes the host model and checker are compiled before it.
module tsa_pipeline_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk, rst_b, run, conv_clk, word_strobe, overflow;
  logic [2:0] half;
  logic [7:0] level, analog_sample, out_word;
  logic [7:0] sent[$];
  logic [7:0] rnd_level[400];
  logic [2:0] rnd_half[400];
  int         err_count = 0;
  int         check_count = 0;
  int         n = 0;
  tsa_pipeline uut (.ref_clk(ref_clk), .rst_b(rst_b), .conv_clk(conv_clk), .analog_sample(analog_sample),
                    .out_word(out_word), .word_strobe(word_strobe), .overflow(overflow));
  tsa_host host (.ref_clk(ref_clk), .run(run), .half(half), .level(level), .conv_clk(conv_clk),
                 .analog_sample(analog_sample));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end
  // Corner codes, then every code in turn, then random levels
  function automatic logic [7:0] pick(int k);
    if (k < 4)
      return k < 2 ? {8{k[0]}} : (k == 2 ? 8'h80 : 8'h7f);
    else if (k < 260)
      return 8'(k - 4);
    return rnd_level[k % 400];
  endfunction : pick
  function automatic logic [7:0] expect_code(logic [7:0] v);
    return v;
  endfunction : expect_code
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_sim();
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic run_to(int target);
    for (int i = 0; i < 20000 && n < target; i++)
      @(posedge ref_clk);
    if (n < target)
    begin
      err_count++;
      end_sim();
    end
  endtask : run_to
  // Each falling edge takes a sample; the next level and half period follow
  always @(negedge conv_clk)
  begin
    if (rst_b === 1'b1)
    begin
      sent.push_back(analog_sample);
      level = pick(n);
      half = rnd_half[n % 400];
      n++;
    end
  end
  // Sampled mid-cycle, where the registered outputs have settled
  always @(negedge ref_clk)
    if (word_strobe === 1'b1 && rst_b === 1'b1)
      check("out_word", sent.size() ? expect_code(sent.pop_front()) : 8'hxx, out_word);
  initial
  begin
    void'($urandom(55));
    foreach (rnd_level[i])
    begin
      rnd_level[i] = 8'($urandom);
      rnd_half[i]  = 3'(4 + $urandom_range(3));
    end
    rst_b = 1'b0;
    run = 1'b0;
    half = 3'h4;
    level = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    run = 1'b1;
    run_to(150);
    #1 run = 1'b0;
    repeat (40) @(posedge ref_clk);
    #1 run = 1'b1;
    run_to(300);
    #1 run = 1'b0;
    repeat (40) @(posedge ref_clk);
    #1 rst_b = 1'b0;
    #5 check("reset out_word", 8'h00, out_word);
    check("reset strobe", 8'h00, {7'h00, word_strobe});
    sent.delete();
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    run = 1'b1;
    run_to(340);
    #1 run = 1'b0;
    repeat (40) @(posedge ref_clk);
    check("overflow", 8'h00, {7'h00, overflow});
    end_sim();
  end
endmodule : tsa_pipeline_tb
